//--- logic/srio_pkg.sv
package srio_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned HOLD_MS = 100;
	localparam int unsigned HOLD_CYCLES = HOLD_MS * CLK_MHZ * 1000;
	localparam int unsigned SLOT_W = 2;
	localparam int unsigned GPIO_W = 4;
	localparam int unsigned JIT_W = 16;
	// jitter in units of 0.01 %
	localparam logic [15:0] RANGE_LIMIT = 16'h07D0;
	localparam logic [1:0] SLOT_HOME = 2'h0;
	localparam logic [1:0] SLOT_LAST = 2'h3;
	localparam logic [3:0] IND_RESET = 4'h0;
	localparam logic [3:0] GPIO_RESET = 4'h0;
	typedef logic [3:0] srio_nib_t;
endpackage

//--- logic/srio_req_if.sv
`timescale 1ns/100ps
interface srio_req_if;
	logic req_n;
	logic fire;
	modport flt (input req_n, output fire);
	modport top (output req_n, input fire);
endinterface

//--- logic/srio_req_filter.sv
`timescale 1ns/100ps
module srio_req_filter #(
	parameter int unsigned HOLD_CYC = srio_pkg::HOLD_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// request carrier
	srio_req_if.flt req
);
	import srio_pkg::*;
	localparam int unsigned CW = $clog2(HOLD_CYC + 1);
	localparam logic [CW-1:0] CNT_END = CW'(HOLD_CYC - 1);

	logic s1_r;
	logic s2_r;
	logic lvl_r;
	logic [CW-1:0] cnt_r;
	logic armed_r;
	logic fire_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			lvl_r <= 1'b1;
		end else begin
			s1_r <= req.req_n;
			s2_r <= s1_r;
			lvl_r <= s2_r;
		end
	end

	// cycles the synced level has been stable
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			cnt_r <= '0;
		else if (s2_r != lvl_r)
			cnt_r <= '0;
		else if (cnt_r != CNT_END)
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			armed_r <= 1'b1;
			fire_r <= 1'b0;
		end else begin
			fire_r <= 1'b0;
			if (armed_r && !s2_r && s2_r == lvl_r && cnt_r == CNT_END) begin
				fire_r <= 1'b1;
				armed_r <= 1'b0;
			end else if (!armed_r && s2_r && s2_r == lvl_r && cnt_r == CNT_END) begin
				armed_r <= 1'b1;
			end
		end
	end

	assign req.fire = fire_r;

	a_fire_single: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fire_r |=> !fire_r && !armed_r) else $error("request fired twice");
	a_fire_low_held: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(fire_r) |-> $past(!s2_r && cnt_r == CNT_END))
		else $error("fire without hold");
	a_rearm_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(armed_r) |-> $past(s2_r)) else $error("rearmed while low");
endmodule

//--- logic/srio_ext_io.sv
// What this block does
// - step-up held low 100 ms adds one, or selects slot 1 if invalid
// - step-down held low 100 ms subtracts one, or selects slot 1 if invalid
// - home held low 100 ms selects slot 1
// - slot indicators driven one-hot per slot
// - panel change invalidates, indicators all low
// - jitter above threshold: pass low, fail high
// - range flag low above 20 percent
// - range flag settles within interval plus 50 ms
// - latency may reach 200 ms when adjusting
// - general inputs sampled, returned on query
// - host written nibble held on outputs
`timescale 1ns/100ps
module srio_ext_io #(
	parameter int unsigned HOLD_CYC = srio_pkg::HOLD_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// recall request pins, active low
	input wire logic step_up_request_n_i,
	input wire logic step_down_request_n_i,
	input wire logic home_request_n_i,
	// general purpose pins
	input wire srio_pkg::srio_nib_t general_in_bits_i,
	output srio_pkg::srio_nib_t general_out_bits_o,
	// host side port access
	input wire logic input_port_query_i,
	output srio_pkg::srio_nib_t input_port_value_o,
	output logic input_port_ready_o,
	input wire logic output_port_write_i,
	input wire srio_pkg::srio_nib_t output_port_data_i,
	// panel and recall handshake
	input wire logic panel_changed_i,
	output logic recall_o,
	output logic [srio_pkg::SLOT_W-1:0] recall_slot_o,
	output srio_pkg::srio_nib_t slot_indicator_bits_o,
	// measurement
	input wire logic jitter_valid_i,
	input wire logic [srio_pkg::JIT_W-1:0] jitter_value_i,
	input wire logic [srio_pkg::JIT_W-1:0] judgement_threshold_i,
	output logic pass_output_o,
	output logic fail_output_o,
	output logic within_range_flag_o
);
	import srio_pkg::*;

	srio_req_if up_if();
	srio_req_if dn_if();
	srio_req_if hm_if();

	assign up_if.req_n = step_up_request_n_i;
	assign dn_if.req_n = step_down_request_n_i;
	assign hm_if.req_n = home_request_n_i;

	srio_req_filter #(.HOLD_CYC(HOLD_CYC)) u_up (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.req(up_if.flt)
	);
	srio_req_filter #(.HOLD_CYC(HOLD_CYC)) u_dn (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.req(dn_if.flt)
	);
	srio_req_filter #(.HOLD_CYC(HOLD_CYC)) u_hm (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.req(hm_if.flt)
	);

	logic fire_up;
	logic fire_dn;
	logic fire_hm;
	logic any_fire;
	assign fire_up = up_if.fire;
	assign fire_dn = dn_if.fire;
	assign fire_hm = hm_if.fire;
	assign any_fire = fire_up | fire_dn | fire_hm;

	// slot pointer
	logic [SLOT_W-1:0] slot_r;
	logic [SLOT_W-1:0] slot_nxt;
	logic valid_r;
	logic valid_nxt;

	// home beats step-up beats step-down if misused together
	always_comb begin
		slot_nxt = slot_r;
		valid_nxt = valid_r;
		if (fire_hm) begin
			slot_nxt = SLOT_HOME;
			valid_nxt = 1'b1;
		end else if (fire_up) begin
			slot_nxt = valid_r ? slot_r + 1'b1 : SLOT_HOME;
			valid_nxt = 1'b1;
		end else if (fire_dn) begin
			slot_nxt = valid_r ? slot_r - 1'b1 : SLOT_HOME;
			valid_nxt = 1'b1;
		end else if (panel_changed_i) begin
			valid_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			slot_r <= SLOT_HOME;
			valid_r <= 1'b0;
			slot_indicator_bits_o <= IND_RESET;
		end else begin
			slot_r <= slot_nxt;
			valid_r <= valid_nxt;
			slot_indicator_bits_o <= valid_nxt ? (4'h1 << slot_nxt) : IND_RESET;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			recall_o <= 1'b0;
			recall_slot_o <= SLOT_HOME;
		end else begin
			recall_o <= any_fire;
			if (any_fire)
				recall_slot_o <= slot_nxt;
		end
	end

	// general inputs come from pins: two-stage synchroniser
	srio_nib_t gin_s1_r;
	srio_nib_t gin_s2_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			gin_s1_r <= GPIO_RESET;
			gin_s2_r <= GPIO_RESET;
		end else begin
			gin_s1_r <= general_in_bits_i;
			gin_s2_r <= gin_s1_r;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			input_port_value_o <= GPIO_RESET;
			input_port_ready_o <= 1'b0;
		end else begin
			input_port_ready_o <= input_port_query_i;
			if (input_port_query_i)
				input_port_value_o <= gin_s2_r;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			general_out_bits_o <= GPIO_RESET;
		else if (output_port_write_i)
			general_out_bits_o <= output_port_data_i;
	end

	// judgement and range, updated one cycle after each new value
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pass_output_o <= 1'b0;
			fail_output_o <= 1'b0;
			within_range_flag_o <= 1'b0;
		end else if (jitter_valid_i) begin
			fail_output_o <= jitter_value_i > judgement_threshold_i;
			pass_output_o <= !(jitter_value_i > judgement_threshold_i);
			within_range_flag_o <= jitter_value_i <= RANGE_LIMIT;
		end
	end

	a_home_slot: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fire_hm |=> slot_indicator_bits_o == 4'h1 && recall_o)
		else $error("home not slot 1");
	a_up_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fire_up && !fire_hm && valid_r && slot_r == SLOT_LAST
		|=> slot_indicator_bits_o == 4'h1) else $error("step up did not wrap");
	a_down_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fire_dn && !fire_up && !fire_hm && valid_r && slot_r == SLOT_HOME
		|=> slot_indicator_bits_o == 4'h8) else $error("step down did not wrap");
	a_step_invalid: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(fire_up || fire_dn) && !fire_hm && !valid_r
		|=> slot_indicator_bits_o == 4'h1 && recall_slot_o == SLOT_HOME)
		else $error("step from invalid not slot 1");
	a_down_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fire_dn && !fire_up && !fire_hm && valid_r
		|=> slot_r == $past(slot_r) - 2'h1 && recall_o) else $error("step down wrong");
	a_up_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fire_up && !fire_hm && valid_r
		|=> slot_r == $past(slot_r) + 2'h1 && recall_o) else $error("step up wrong");
	a_ind_onehot: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		##1 (valid_r ? slot_indicator_bits_o == (4'h1 << slot_r)
		: slot_indicator_bits_o == 4'h0)) else $error("indicator mismatch");
	a_recall_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		recall_o |-> slot_indicator_bits_o == (4'h1 << recall_slot_o))
		else $error("recall slot and indicator differ");
	a_ind_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!any_fire && !panel_changed_i |=> $stable(slot_indicator_bits_o))
		else $error("indicator changed without cause");
	a_recall_once: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		recall_o |=> !recall_o)
		else $error("recall longer than one cycle");
	a_panel_invalid: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		panel_changed_i && !any_fire |=> slot_indicator_bits_o == 4'h0 && !valid_r)
		else $error("change not invalidating");
	a_fail_judgement_threshold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		jitter_valid_i && jitter_value_i > judgement_threshold_i
		|=> fail_output_o && !pass_output_o) else $error("fail judgement wrong");
	a_pass_judgement_threshold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		jitter_valid_i && jitter_value_i <= judgement_threshold_i
		|=> pass_output_o && !fail_output_o) else $error("pass judgement wrong");
	a_judgement_threshold_exclusive: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!(pass_output_o && fail_output_o))
		else $error("pass and fail together");
	a_range_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		jitter_valid_i |=> within_range_flag_o == ($past(jitter_value_i) <= RANGE_LIMIT))
		else $error("range flag wrong");
	a_out_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!output_port_write_i |=> $stable(general_out_bits_o))
		else $error("output changed");
	a_in_sample: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		input_port_query_i |=> input_port_ready_o && input_port_value_o == $past(gin_s2_r))
		else $error("input sample wrong");
	a_ready_query: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		input_port_ready_o |-> $past(input_port_query_i))
		else $error("ready without query");
endmodule

//--- verif/srio_jig.sv
`timescale 1ns/100ps
module srio_jig (
	// contact closures, bit0 up, bit1 down, bit2 home
	input wire logic [2:0] close_i,
	// request pins, pulled up when open
	output logic [2:0] pin_n_o
);
	always_comb begin
		pin_n_o = 3'h7;
		// never more than one contact at once
		if ($onehot(close_i)) begin
			pin_n_o = ~close_i;
		end
	end
endmodule

//--- verif/test_setup_recall_ext_io.sv
`timescale 1ns/100ps
module test_setup_recall_ext_io;
	import srio_pkg::*;
	localparam int unsigned HC = 8;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [2:0] close = 3'h0;
	logic [2:0] pin_n;
	srio_nib_t gin = 4'h0;
	srio_nib_t odat = 4'h0;
	srio_nib_t gout, pval, ind;
	logic q = 1'b0;
	logic wr = 1'b0;
	logic pch = 1'b0;
	logic jv = 1'b0;
	logic rdy, rec, pass, fail, inr;
	logic [1:0] slot;
	logic [JIT_W-1:0] jit = 16'h0000;
	logic [JIT_W-1:0] thr = 16'h0000;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	int pulses;
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 1500) begin
			error_cnt = error_cnt + 1;
			conclude();
		end
	end
	srio_jig jig (.close_i(close), .pin_n_o(pin_n));
	srio_ext_io #(.HOLD_CYC(HC)) dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.step_up_request_n_i(pin_n[0]), .step_down_request_n_i(pin_n[1]),
		.home_request_n_i(pin_n[2]),
		.general_in_bits_i(gin), .general_out_bits_o(gout),
		.input_port_query_i(q), .input_port_value_o(pval), .input_port_ready_o(rdy),
		.output_port_write_i(wr), .output_port_data_i(odat),
		.panel_changed_i(pch), .recall_o(rec), .recall_slot_o(slot),
		.slot_indicator_bits_o(ind),
		.jitter_valid_i(jv), .jitter_value_i(jit), .judgement_threshold_i(thr),
		.pass_output_o(pass), .fail_output_o(fail), .within_range_flag_o(inr)
	);
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input logic [2:0] c, input int n, input int p, input logic [3:0] e);
		pulses = 0;
		close = c;
		for (int k = 1; k <= n + HC + 4; k++) begin
			@(negedge ref_clk_i);
			if (k == n) begin
				// open long enough to rearm
				close = 3'h0;
			end
			if (rec === 1'b1) begin
				pulses++;
			end
		end
		chk(ind, e);
		chk(4'(pulses), 4'(p));
		if (p > 0) begin
			chk(4'h1 << slot, e);
		end
	endtask
	task automatic panel();
		pch = 1'b1;
		@(negedge ref_clk_i);
		pch = 1'b0;
		@(negedge ref_clk_i);
		chk(ind, 4'h0);
	endtask
	task automatic ports();
		for (int i = 0; i < 16; i += 5) begin
			gin = 4'(i);
			odat = ~4'(i);
			wr = 1'b1;
			@(negedge ref_clk_i);
			wr = 1'b0;
			repeat (2) @(negedge ref_clk_i);
			q = 1'b1;
			@(negedge ref_clk_i);
			q = 1'b0;
			chk(gout, ~4'(i));
			chk({3'h0, rdy}, 4'h1);
			chk(pval, 4'(i));
		end
	endtask
	task automatic meas();
		for (int k = 0; k < 4; k++) begin
			thr = (k == 3) ? 16'h0100 : RANGE_LIMIT;
			jit = 16'h07CF + 16'(k % 3);
			jv = 1'b1;
			@(negedge ref_clk_i);
			jv = 1'b0;
			chk({2'h0, pass, fail}, {2'h0, jit <= thr, jit > thr});
			chk({3'h0, inr}, {3'h0, jit <= RANGE_LIMIT});
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		chk(ind, IND_RESET);
		step(3'h1, HC + 10, 1, 4'h1);
		step(3'h1, HC + 10, 1, 4'h2);
		step(3'h1, HC + 10, 1, 4'h4);
		step(3'h1, HC + 10, 1, 4'h8);
		step(3'h1, HC + 10, 1, 4'h1);
		step(3'h2, HC + 10, 1, 4'h8);
		step(3'h1, HC - 2, 0, 4'h8);
		step(3'h4, HC + 10, 1, 4'h1);
		panel();
		step(3'h2, HC + 10, 1, 4'h1);
		ports();
		meas();
		conclude();
	end
endmodule
